// file: verilog/i2cev_pkg.sv
package i2cev_pkg;
  // register byte offsets
  localparam logic [7:0] I2CEV_CTRL_OFS  = 8'h00;
  localparam logic [7:0] I2CEV_STAT_OFS  = 8'h04;
  localparam logic [7:0] I2CEV_SHIFT_OFS = 8'h08;
  localparam logic [7:0] I2CEV_FLAG_OFS  = 8'h0C;
  // bus_control_reg fields
  localparam int CTRL_EN   = 7;
  localparam int CTRL_WREL = 5;
  localparam int CTRL_SPIE = 4;
  localparam int CTRL_WTIM = 3;
  localparam int CTRL_ACKE = 2;
  localparam int CTRL_STT  = 1;
  localparam int CTRL_SPT  = 0;
  // bus_status_reg fields
  localparam int STAT_MSTS = 7;
  localparam int STAT_TRC  = 3;
  localparam int STAT_ACKD = 2;
  localparam int STAT_STD  = 1;
  localparam int STAT_SPD  = 0;
  // bus_flag_reg fields
  localparam int FLAG_CLD   = 3;
  localparam int FLAG_DAD   = 2;
  localparam int FLAG_START_WITHOUT_STOP_OPTION = 1;
  localparam int FLAG_RSV   = 0;
  localparam logic [7:0] I2CEV_CTRL_RST = 8'h00;
  localparam logic [7:0] I2CEV_FLAG_RST = 8'h00;
  localparam logic [7:0] I2CEV_FF       = 8'hFF;
  localparam logic [1:0] AXI_OKAY       = 2'h0;
  localparam logic [1:0] AXI_SLVERR     = 2'h2;
  // quarter of a bus clock period
  localparam int CLK_MHZ     = 50;
  localparam int QUARTER_NS  = 2500;
  localparam int QUARTER_CYC = (QUARTER_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    I2CEV_IDLE  = 3'b000,
    I2CEV_START = 3'b001,
    I2CEV_BIT   = 3'b010,
    I2CEV_WAIT  = 3'b011,
    I2CEV_STOP  = 3'b100
  } i2cev_state_e;
  typedef enum logic [1:0] {
    I2CEV_WK_ADDR = 2'b00,
    I2CEV_WK_8    = 2'b01,
    I2CEV_WK_9    = 2'b10
  } i2cev_wait_e;
endpackage

// file: verilog/i2cev_top.sv
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Behaviour
// - address acked interrupt shows master, start, ack
// - eight-clock mode interrupts at eighth clock of a data byte, flags clear
// - nine-clock mode interrupts at ninth clock, ack shown
// - byte interrupts always; stop interrupt only when enabled
// - switching to nine-clock gives ninth-clock interrupt
// - nine-clock restart at ninth clock; address shows start
// - shift register write sends byte, releases wait
// - reception uses ack enable and wait release
// - status bit7 master, bit1 start, bit0 stop
module i2cev_top
  import i2cev_pkg::*;
#(
  parameter int QCYC = QUARTER_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire logic       clock_line_pin_in,
  output logic            clock_line_pin_out,
  output logic            clock_line_pin_oe,
  input  wire logic       data_line_pin_in,
  output logic            data_line_pin_out,
  output logic            data_line_pin_oe,
  output logic            transfer_irq
);
  i2cev_state_e state_reg;
  i2cev_wait_e  wkind_reg;
  logic [1:0]  phase_reg;
  logic [3:0]  bitn_reg;
  logic [7:0]  shift_reg;
  logic        addr_reg;
  logic        rxbit_reg;
  logic [15:0] qcnt_reg;
  logic [1:0]  scl_sync_reg, sda_sync_reg;
  logic        scl_d_reg, sda_d_reg;
  logic        en_reg, spie_reg, wtim_reg, acke_reg, stt_reg, spt_reg;
  logic        start_without_stop_option_reg, rsv_reg, en_d_reg, busy_reg;
  logic        msts_reg, trc_reg, ackd_reg, std_reg, spd_reg;
  logic        scl_low_reg, sda_low_reg, irq_reg;
  logic        bvalid_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic        scl_s, sda_s, start_det, stop_det, tick;
  logic        wr_go, rd_go, wr_ctrl, wr_shift, wr_flag, wrel;
  logic        sample, end_bit, irq8, irq9, start_done, stop_done, data_go;
  logic        scl_low_next, sda_low_next, map_ok;
  logic [31:0] rdata_next;

  // two-stage synchronisers; edge detection compares the second stage with its delayed copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], clock_line_pin_in};
      sda_sync_reg <= {sda_sync_reg[0], data_line_pin_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end
  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // axi4-lite slave: address and data taken together, one outstanding each
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid && !rvalid_reg;
  assign s_axi_arready = rd_go;
  assign wr_ctrl  = wr_go && s_axi_wstrb[0] && s_axi_awaddr == I2CEV_CTRL_OFS;
  assign wr_shift = wr_go && s_axi_wstrb[0] && s_axi_awaddr == I2CEV_SHIFT_OFS;
  assign wr_flag  = wr_go && s_axi_wstrb[0] && s_axi_awaddr == I2CEV_FLAG_OFS;
  assign wrel     = wr_ctrl && s_axi_wdata[CTRL_WREL];
  assign map_ok   = s_axi_awaddr == I2CEV_CTRL_OFS || s_axi_awaddr == I2CEV_STAT_OFS ||
                    s_axi_awaddr == I2CEV_SHIFT_OFS || s_axi_awaddr == I2CEV_FLAG_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= AXI_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= map_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_comb begin
    rdata_next = 32'h0;
    if (s_axi_araddr == I2CEV_CTRL_OFS) begin
      rdata_next[7:0] = {en_reg, 2'h0, spie_reg, wtim_reg, acke_reg, stt_reg, spt_reg};
    end else if (s_axi_araddr == I2CEV_STAT_OFS) begin
      rdata_next[7:0] = {msts_reg, 3'h0, trc_reg, ackd_reg, std_reg, spd_reg};
    end else if (s_axi_araddr == I2CEV_SHIFT_OFS) begin
      rdata_next[7:0] = shift_reg;
    end else if (s_axi_araddr == I2CEV_FLAG_OFS) begin
      rdata_next[7:0] = {4'h0, scl_s, sda_s, start_without_stop_option_reg, rsv_reg};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= AXI_OKAY;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdata_next;
      rresp_reg  <= (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= I2CEV_FLAG_OFS) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // control and flag registers; a request write wins over the hardware clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {en_reg, spie_reg, wtim_reg, acke_reg} <= I2CEV_CTRL_RST[7:4];
      stt_reg   <= 1'b0;
      spt_reg   <= 1'b0;
      start_without_stop_option_reg <= I2CEV_FLAG_RST[FLAG_START_WITHOUT_STOP_OPTION];
      rsv_reg   <= I2CEV_FLAG_RST[FLAG_RSV];
    end else begin
      if ((state_reg == I2CEV_IDLE && stt_reg && (busy_reg && rsv_reg)) || start_done || !en_reg) begin
        stt_reg <= 1'b0;
      end
      if (stop_done || !en_reg) begin
        spt_reg <= 1'b0;
      end
      if (wr_ctrl) begin
        en_reg   <= s_axi_wdata[CTRL_EN];
        spie_reg <= s_axi_wdata[CTRL_SPIE];
        wtim_reg <= s_axi_wdata[CTRL_WTIM];
        acke_reg <= s_axi_wdata[CTRL_ACKE];
        if (s_axi_wdata[CTRL_STT]) stt_reg <= 1'b1;
        if (s_axi_wdata[CTRL_SPT]) spt_reg <= 1'b1;
      end
      if (wr_flag) begin
        start_without_stop_option_reg <= s_axi_wdata[FLAG_START_WITHOUT_STOP_OPTION];
        rsv_reg   <= s_axi_wdata[FLAG_RSV];
      end
    end
  end

  // bus busy: without the option the bus counts as taken until a stop is seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_d_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      en_d_reg <= en_reg;
      if (en_reg && !en_d_reg) busy_reg <= !start_without_stop_option_reg;
      else if (start_det)      busy_reg <= 1'b1;
      else if (stop_det)       busy_reg <= 1'b0;
    end
  end

  // quarter-bit timebase
  always_ff @(posedge aclk) begin
    if (!aresetn || qcnt_reg == 16'(QCYC - 1)) qcnt_reg <= 16'h0;
    else                                      qcnt_reg <= qcnt_reg + 16'h1;
  end
  assign tick = qcnt_reg == 16'(QCYC - 1);

  assign sample     = state_reg == I2CEV_BIT && tick && phase_reg == 2'h2;
  assign end_bit    = state_reg == I2CEV_BIT && tick && phase_reg == 2'h3;
  assign irq8       = end_bit && bitn_reg == 4'h7 && !wtim_reg && !addr_reg;
  assign irq9       = end_bit && bitn_reg == 4'h8;
  assign start_done = state_reg == I2CEV_START && tick && phase_reg == 2'h2;
  assign stop_done  = state_reg == I2CEV_STOP && tick && phase_reg == 2'h2;
  assign data_go    = state_reg == I2CEV_WAIT && wkind_reg == I2CEV_WK_9 && !stt_reg && !spt_reg &&
                      (wr_shift || wrel);

  // transfer engine
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_reg) begin
      state_reg <= I2CEV_IDLE;
      wkind_reg <= I2CEV_WK_ADDR;
      phase_reg <= 2'h0;
      bitn_reg  <= 4'h0;
      shift_reg <= 8'h0;
      addr_reg  <= 1'b0;
      rxbit_reg <= 1'b0;
    end else begin
      case (state_reg)
        I2CEV_IDLE: begin
          phase_reg <= 2'h0;
          if (spt_reg) begin
            state_reg <= I2CEV_STOP;
          // busy settles one cycle after enable; without the option, hold the start until then
          end else if (stt_reg && !busy_reg && (start_without_stop_option_reg || en_d_reg)) begin
            state_reg <= I2CEV_START;
          end
        end
        I2CEV_START, I2CEV_STOP: begin
          if (tick && !(phase_reg == 2'h1 && !scl_s)) phase_reg <= phase_reg + 2'h1;
          if (start_done) begin
            state_reg <= I2CEV_WAIT;
            wkind_reg <= I2CEV_WK_ADDR;
            phase_reg <= 2'h0;
          end
          if (stop_done) state_reg <= I2CEV_IDLE;
        end
        I2CEV_BIT: begin
          // clock stretching: high phase waits for the line to read high
          if (tick && !(phase_reg == 2'h1 && !scl_s)) phase_reg <= phase_reg + 2'h1;
          // shift at the end of the bit, clock low, so data never moves under a high clock
          if (sample) rxbit_reg <= sda_s;
          if (end_bit) begin
            bitn_reg <= bitn_reg + 4'h1;
            if (bitn_reg != 4'h8) shift_reg <= {shift_reg[6:0], rxbit_reg};
            if (irq8) begin
              state_reg <= I2CEV_WAIT;
              wkind_reg <= I2CEV_WK_8;
            end else if (irq9) begin
              state_reg <= I2CEV_WAIT;
              wkind_reg <= I2CEV_WK_9;
            end
          end
        end
        I2CEV_WAIT: begin
          phase_reg <= 2'h0;
          if (wkind_reg == I2CEV_WK_8) begin
            if (wrel || wr_shift) begin
              state_reg <= I2CEV_BIT;
              bitn_reg  <= 4'h8;
            end
          end else if (stt_reg && wkind_reg == I2CEV_WK_9) begin
            state_reg <= I2CEV_START;
          end else if (spt_reg) begin
            state_reg <= I2CEV_STOP;
          end else if (wr_shift) begin
            state_reg <= I2CEV_BIT;
            bitn_reg  <= 4'h0;
            shift_reg <= s_axi_wdata[7:0];
            addr_reg  <= wkind_reg == I2CEV_WK_ADDR;
          end else if (wrel && wkind_reg == I2CEV_WK_9) begin
            state_reg <= I2CEV_BIT;
            bitn_reg  <= 4'h0;
            shift_reg <= I2CEV_FF;
            addr_reg  <= 1'b0;
          end
        end
        default: state_reg <= I2CEV_IDLE;
      endcase
    end
  end

  // line drive; ack bit driven low only when receiving with ack enabled
  always_comb begin
    scl_low_next = 1'b0;
    sda_low_next = 1'b0;
    case (state_reg)
      I2CEV_START: begin
        scl_low_next = phase_reg == 2'h2;
        sda_low_next = phase_reg != 2'h0;
      end
      I2CEV_STOP: begin
        scl_low_next = phase_reg == 2'h0;
        sda_low_next = phase_reg != 2'h2;
      end
      I2CEV_BIT: begin
        scl_low_next = phase_reg == 2'h0 || phase_reg == 2'h3;
        sda_low_next = (bitn_reg == 4'h8) ? (!trc_reg && acke_reg) : !shift_reg[7];
      end
      I2CEV_WAIT: begin
        scl_low_next = 1'b1;
        sda_low_next = wkind_reg == I2CEV_WK_ADDR;
      end
      default: begin
        scl_low_next = 1'b0;
        sda_low_next = 1'b0;
      end
    endcase
  end

  // status flags change on bus events, on shift register or wait release writes and on clearing the enable bit, and hold in between
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_reg) begin
      {msts_reg, trc_reg, ackd_reg, std_reg, spd_reg} <= 5'h0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
      irq_reg     <= irq8 || irq9 || (stop_det && spie_reg);
      if (stop_done) msts_reg <= 1'b0;
      else if (start_done) msts_reg <= 1'b1;
      if (data_go || stop_det) std_reg <= 1'b0;
      if (start_det) std_reg <= 1'b1;
      if (start_det) spd_reg <= 1'b0;
      if (stop_det) spd_reg <= 1'b1;
      if (data_go || stop_det) ackd_reg <= 1'b0;
      if (sample && bitn_reg == 4'h8) ackd_reg <= !sda_s;
      if (stop_det) trc_reg <= 1'b0;
      else if (state_reg == I2CEV_WAIT && wkind_reg == I2CEV_WK_ADDR && wr_shift) trc_reg <= 1'b1;
      else if (irq9 && addr_reg) trc_reg <= !shift_reg[0];
    end
  end

  assign clock_line_pin_out = 1'b0;
  assign clock_line_pin_oe  = scl_low_reg;
  assign data_line_pin_out  = 1'b0;
  assign data_line_pin_oe   = sda_low_reg;
  assign transfer_irq       = irq_reg;
endmodule

// file: dv/i2cev_top_asserts.sv
`timescale 1ns/10ps
module i2cev_top_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        clock_line_pin_out,
  input wire logic        clock_line_pin_oe,
  input wire logic        data_line_pin_out,
  input wire logic        transfer_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_take_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");
  a_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stuck");
  a_write_ready_term: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("write ready term wrong");
  a_read_ready_term: assert property (s_axi_arready == (s_axi_arvalid && !s_axi_rvalid))
    else $error("read ready term wrong");
  a_read_take_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_read_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed");
  a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read upper bits set");
  a_irq_one_pulse: assert property (transfer_irq |=> !transfer_irq)
    else $error("interrupt pulse too long");
  a_pins_drive_low: assert property (!clock_line_pin_out && !data_line_pin_out)
    else $error("line driven high");
  a_wait_holds_clock: assert property (transfer_irq && clock_line_pin_oe |=> clock_line_pin_oe)
    else $error("clock released right after byte interrupt");
  c_irq: cover property (transfer_irq);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind i2cev_top i2cev_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .clock_line_pin_out(clock_line_pin_out),
  .clock_line_pin_oe(clock_line_pin_oe), .data_line_pin_out(data_line_pin_out), .transfer_irq(transfer_irq));

// file: dv/i2cev_peer.sv
`timescale 1ns/10ps
// slave that acks every byte; never stretches the clock
module i2cev_peer (
  input wire logic  scl,
  input wire logic  sda,
  output logic      sda_low,
  output logic [7:0] rx_byte,
  output logic      rx_stb
);
  int         bit_cnt = 0;
  logic [7:0] sh;
  initial begin
    sda_low = 1'b0;
    rx_stb  = 1'b0;
  end
  // start or stop framing restarts the bit count
  always @(sda) begin
    if (scl === 1'b1) begin
      bit_cnt = 0;
    end
  end
  always @(posedge scl) begin
    if (bit_cnt < 8) begin
      sh = {sh[6:0], sda};
    end
    bit_cnt++;
    if (bit_cnt == 8) begin
      rx_byte = sh;
      rx_stb  = ~rx_stb;
    end
  end
  always @(negedge scl) begin
    sda_low = (bit_cnt == 8);
    if (bit_cnt == 9) begin
      bit_cnt = 0;
    end
  end
endmodule

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
  import i2cev_pkg::*;
  logic        aclk, aresetn, awv, wv, br, arv, rr, awr, wr_r, bv, arr, rv;
  logic [7:0]  awa, ara, pb;
  logic [31:0] wd, rdat, lf, v;
  logic [3:0]  ws;
  logic [1:0]  brs, rrs, rs;
  logic        scl_oe, sda_oe, irq, plow, pstb;
  logic [7:0]  exp_q[$];
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || plow);
  int          failures = 0, samples_checked = 0, irq_cnt = 0, tgt = 0, cyc = 0;
  i2cev_top #(.QCYC(2)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .clock_line_pin_in(scl), .clock_line_pin_out(), .clock_line_pin_oe(scl_oe), .data_line_pin_in(sda),
    .data_line_pin_out(), .data_line_pin_oe(sda_oe), .transfer_irq(irq));
  i2cev_peer u_peer (.scl(scl), .sda(sda), .sda_low(plow), .rx_byte(pb), .rx_stb(pstb));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      failures++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awa <= a;
    wd  <= {24'h000000, d};
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    do @(posedge aclk); while (awr !== 1'b1);
    awv <= 1'b0;
    wv  <= 1'b0;
    while (bv !== 1'b1) @(posedge aclk);
    br  <= 1'b0;
    rs = brs;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge aclk);
    rr  <= 1'b0;
    rs = rrs;
    chk(rdat & m, e);
  endtask
  task automatic snd(input logic [7:0] b);
    exp_q.push_back(b);
    wr(I2CEV_SHIFT_OFS, b);
  endtask
  // the pulse lasts one cycle, so it is counted on its own
  task automatic wirq;
    int k;
    k = 0;
    tgt++;
    while (irq_cnt < tgt && k < 400) begin
      @(posedge aclk);
      k++;
    end
    chk(32'(irq_cnt), 32'(tgt));
  endtask
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (irq === 1'b1) irq_cnt++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  always @(pstb) begin
    if (exp_q.size() > 0) chk({24'h000000, pb}, {24'h000000, exp_q.pop_front()});
  end
  initial begin
    aresetn = 1'b0;
    awa = 8'h00;
    ara = 8'h00;
    wd  = 32'h00000000;
    ws  = 4'hF;
    awv = 1'b0;
    wv  = 1'b0;
    br  = 1'b0;
    arv = 1'b0;
    rr  = 1'b0;
    lf  = 32'h574CCDEC;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(I2CEV_CTRL_OFS, 32'hFF, 32'h00);
    rd(I2CEV_STAT_OFS, 32'hFF, 32'h00);
    rd(I2CEV_FLAG_OFS, 32'hFF, 32'h0C);
    rd(8'h10, 32'hFF, 32'h00);
    chk(32'(rs), 32'(AXI_SLVERR));
    // option clear: bus counts busy after enable, so the start waits for a stop
    wr(I2CEV_CTRL_OFS, 8'h92);
    repeat (20) @(posedge aclk);
    rd(I2CEV_STAT_OFS, 32'hFF, 32'h00);
    wr(I2CEV_CTRL_OFS, 8'h93);
    wirq();
    repeat (20) @(posedge aclk);
    rd(I2CEV_STAT_OFS, 32'hFF, 32'h82);
    wr(I2CEV_CTRL_OFS, 8'h91);
    wirq();
    rd(I2CEV_STAT_OFS, 32'hFF, 32'h01);
    $display("test reserved start done");
    // start allowed without a prior stop
    wr(I2CEV_FLAG_OFS, 8'h02);
    for (int m = 0; m < 2; m++) begin
      wr(I2CEV_CTRL_OFS, {4'h9, m[0], 3'h6});
      repeat (20) @(posedge aclk);
      snd(8'hA0);
      wirq();
      rd(I2CEV_STAT_OFS, 32'hF7, 32'h86);
      rd(I2CEV_FLAG_OFS, 32'hFF, 32'h06);
      lf = lfsr(lf);
      snd(lf[7:0]);
      wirq();
      rd(I2CEV_STAT_OFS, 32'hF7, m ? 32'h84 : 32'h80);
      rd(I2CEV_SHIFT_OFS, 32'hFF, {24'h000000, lf[7:0]});
      if (m == 0) begin
        wr(I2CEV_CTRL_OFS, 8'hBC);
        wirq();
        rd(I2CEV_STAT_OFS, 32'hF3, 32'h80);
      end
      wr(I2CEV_CTRL_OFS, {4'h9, m[0], 3'h6});
      repeat (40) @(posedge aclk);
      snd(8'hA2);
      wirq();
      rd(I2CEV_STAT_OFS, 32'hF7, 32'h86);
      wr(I2CEV_CTRL_OFS, {3'h4, ~m[0], m[0], 3'h5});
      if (m == 0) begin
        wirq();
        rd(I2CEV_STAT_OFS, 32'hFF, 32'h01);
      end else begin
        repeat (300) @(posedge aclk);
        chk(32'(irq_cnt), 32'(tgt));
      end
      $display("test mode %0d done", m);
    end
    chk(32'(exp_q.size()), 32'h0);
    tally_and_finish();
  end
endmodule
